// ===== iprr_top.sv
/*
 * interrupt priority resolver: request flags, enables, packed priority
 * fields and global controls behind an axi4-lite slave; presents the
 * winning interrupt number, vector and level to the processor core.
 * assumes source events are one-clock pulses from logic on i_clk, and
 * i_in_service is driven by the core on the same clock.
 */
// The address map and the AXI4-Lite register port are this design's own decisions.
// Operation
// - three-bit level in low bits of nibble
// - nibble top bit ignores writes, reads zero
// - level zero lowest, seven highest
// - natural order breaks ties at equal level
// - lower interrupt number wins a tie
// - natural rank equals interrupt number
// - vector number is interrupt number plus eight
// - fixed source numbers; reserved numbers never request
// - user level dominates natural order
// - level zero source is never presented
// - flag sets regardless of enable; enabled competes
// - nesting disable blocks requests while the core is in service, freezes cpu level
// - temporary mask holds off levels six and below
`timescale 1ns/1ps

module iprr_top
    import iprr_pkg::*;
(
    input wire logic i_clk,                    // 25 mhz instruction clock
    input wire logic i_reset,                  // sync reset, active high
    input wire logic [`IPRR_NSRC-1:0] i_src_event, // one-clock source events
    input wire logic i_in_service,             // core is servicing an interrupt
    input wire logic [7:0] s_axi_awaddr,       // write address
    input wire logic s_axi_awvalid,            // write address valid
    output logic s_axi_awready,                // write address ready
    input wire logic [31:0] s_axi_wdata,       // write data
    input wire logic [3:0] s_axi_wstrb,        // write byte strobes
    input wire logic s_axi_wvalid,             // write data valid
    output logic s_axi_wready,                 // write data ready
    output logic [1:0] s_axi_bresp,            // write response
    output logic s_axi_bvalid,                 // write response valid
    input wire logic s_axi_bready,             // write response ready
    input wire logic [7:0] s_axi_araddr,       // read address
    input wire logic s_axi_arvalid,            // read address valid
    output logic s_axi_arready,                // read address ready
    output logic [31:0] s_axi_rdata,           // read data
    output logic [1:0] s_axi_rresp,            // read response
    output logic s_axi_rvalid,                 // read data valid
    input wire logic s_axi_rready,             // read data ready
    output logic o_req,                        // request presented to core
    output iprr_src_type o_req_num,            // interrupt number presented
    output logic [6:0] o_req_vector,           // vector number presented
    output iprr_level_type o_req_level,        // level presented
    output logic o_irq                         // unmasked status bit set
);

    ////////////////////////////////////////////////////////////////////////
    // state

    iprr_vec_type flag_q;                      // request_flag_reg bits
    iprr_vec_type en_q;                        // request_enable_reg bits
    iprr_levels_type prio_q;                   // priority_config_regs fields
    logic nest_dis_q;                          // nesting_disable
    logic temp_mask_q;                         // temporary_mask
    logic [3:0] cpu_lvl_q;                     // cpu_priority_level
    logic [1:0] irq_stat_q;                    // sticky event status
    logic [1:0] irq_mask_q;                    // event mask
    logic [7:0] awaddr_q;                      // captured write address
    logic [31:0] wdata_q;                      // captured write data
    logic [3:0] wstrb_q;                       // captured strobes
    logic awready_q;                           // address slot free
    logic wready_q;                            // data slot free
    logic bvalid_q;                            // write answer pending
    logic [1:0] bresp_q;                       // write answer code
    logic arready_q;                           // read slot free
    logic rvalid_q;                            // read answer pending
    logic [31:0] rdata_q;                      // read answer data
    logic [1:0] rresp_q;                       // read answer code
    logic req_q;                               // presented request
    iprr_src_type req_num_q;                   // presented number
    logic [6:0] req_vec_q;                     // presented vector
    iprr_level_type req_lvl_q;                 // presented level
    logic irq_q;                               // interrupt output
    localparam iprr_vec_type impl_mask = `IPRR_IMPL_MASK; // sources that exist

    logic wr_fire;                             // both halves of a write held
    logic [5:0] wr_idx;                        // word index of write
    logic wr_mapped;                           // write hits a register
    logic [31:0] rd_word;                      // read mux output
    logic rd_mapped;                           // read hits a register
    logic present_d;                           // winner may be presented
    logic [1:0] ev;                            // events this cycle
    logic [1:0] irq_stat_d;                    // next status

    iprr_resolve_if rif ();                    // resolver carrier

    ////////////////////////////////////////////////////////////////////////
    // winner search

    assign rif.pending = flag_q & en_q;
    assign rif.levels = prio_q;

    iprr_resolver u_resolver (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .rif(rif.resolver)
    );

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data in either order

    assign wr_fire = !awready_q && !wready_q && !bvalid_q;
    assign wr_idx = awaddr_q[7:2];
    assign wr_mapped = (awaddr_q <= `IPRR_OFF_IRQ_MASK) && (awaddr_q[1:0] == 2'h0);

    // capture address, data; answer once both are held
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `IPRR_RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= `IPRR_RST_WORD;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awaddr_q <= s_axi_awaddr;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                wready_q <= 1'b0;
            end
            if (wr_fire) begin
                // unmapped address still answers, with an error code
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? `IPRR_RESP_OKAY : `IPRR_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request flags: software writes, source events set; set wins

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            flag_q <= '0;
        end else begin
            for (int k = 0; k < `IPRR_NSRC; k++) begin
                if (wr_fire && wr_mapped && wr_idx == 6'(k / 32) && wstrb_q[(k % 32) / 8]) begin
                    flag_q[k] <= (wdata_q[k % 32] || i_src_event[k]) && impl_mask[k];
                end else begin
                    flag_q[k] <= (flag_q[k] || i_src_event[k]) && impl_mask[k];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enables and priority nibbles

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            en_q <= '0;
            prio_q <= '0;
        end else if (wr_fire && wr_mapped) begin
            for (int k = 0; k < `IPRR_NSRC; k++) begin
                if (wr_idx == 6'(2 + k / 32) && wstrb_q[(k % 32) / 8]) begin
                    en_q[k] <= wdata_q[k % 32] && impl_mask[k];
                end
                // only the low three bits of a nibble are stored
                if (wr_idx == 6'(4 + k / `IPRR_NIB_PER_WORD) && wstrb_q[(k % `IPRR_NIB_PER_WORD) / 2]) begin
                    prio_q[k] <= wdata_q[(k % `IPRR_NIB_PER_WORD) * 4 +: 3];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // global controls and cpu level

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            nest_dis_q <= 1'b0;
            temp_mask_q <= 1'b0;
            cpu_lvl_q <= `IPRR_RST_CPU_LVL;
            irq_mask_q <= 2'h0;
        end else if (wr_fire) begin
            if (awaddr_q == `IPRR_OFF_CTL_ONE && wstrb_q[1]) begin
                nest_dis_q <= wdata_q[`IPRR_BIT_NEST_DIS];
            end
            if (awaddr_q == `IPRR_OFF_CTL_TWO && wstrb_q[1]) begin
                temp_mask_q <= wdata_q[`IPRR_BIT_TEMP_MASK];
            end
            // level is frozen while nesting is disabled
            if (awaddr_q == `IPRR_OFF_CPU_LVL && wstrb_q[0] && !nest_dis_q) begin
                cpu_lvl_q <= wdata_q[3:0];
            end
            if (awaddr_q == `IPRR_OFF_IRQ_MASK && wstrb_q[0]) begin
                irq_mask_q <= wdata_q[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel

    assign rd_mapped = (s_axi_araddr <= `IPRR_OFF_IRQ_MASK) && (s_axi_araddr[1:0] == 2'h0);

    // read mux; unused bits and nibble top bits read zero
    always_comb begin
        rd_word = `IPRR_RST_WORD;
        case (s_axi_araddr)
            `IPRR_OFF_FLAG_LO: rd_word = flag_q[31:0];
            `IPRR_OFF_FLAG_HI: rd_word = {10'h000, flag_q[53:32]};
            `IPRR_OFF_EN_LO: rd_word = en_q[31:0];
            `IPRR_OFF_EN_HI: rd_word = {10'h000, en_q[53:32]};
            `IPRR_OFF_CTL_ONE: rd_word[`IPRR_BIT_NEST_DIS] = nest_dis_q;
            `IPRR_OFF_CTL_TWO: rd_word[`IPRR_BIT_TEMP_MASK] = temp_mask_q;
            `IPRR_OFF_CPU_LVL: rd_word[3:0] = cpu_lvl_q;
            `IPRR_OFF_WIN_STAT: rd_word = {16'h0000, req_q, req_lvl_q, req_vec_q[5:0], req_num_q};
            `IPRR_OFF_IRQ_STAT: rd_word[1:0] = irq_stat_q;
            `IPRR_OFF_IRQ_MASK: rd_word[1:0] = irq_mask_q;
            default: begin
                for (int k = 0; k < `IPRR_NSRC; k++) begin
                    if (s_axi_araddr[7:2] == 6'(4 + k / `IPRR_NIB_PER_WORD)) begin
                        rd_word[(k % `IPRR_NIB_PER_WORD) * 4 +: 4] = {1'b0, prio_q[k]};
                    end
                end
            end
        endcase
    end

    // one read at a time, answered the cycle after acceptance
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= `IPRR_RST_WORD;
            rresp_q <= `IPRR_RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mapped ? rd_word : `IPRR_RST_WORD;
            rresp_q <= rd_mapped ? `IPRR_RESP_OKAY : `IPRR_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // presentation gate towards the core

    assign present_d = rif.win_valid
        && ({1'b0, rif.win_level} > cpu_lvl_q)
        && !(nest_dis_q && i_in_service)
        && !(temp_mask_q && rif.win_level != `IPRR_TOP_LEVEL);

    // register the winner so the core sees stable outputs
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            req_q <= 1'b0;
            req_num_q <= 6'h00;
            req_vec_q <= `IPRR_VEC_BASE;
            req_lvl_q <= `IPRR_RST_LEVEL;
        end else begin
            req_q <= present_d;
            req_num_q <= rif.win_num;
            req_vec_q <= {1'b0, rif.win_num} + `IPRR_VEC_BASE;
            req_lvl_q <= rif.win_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // block interrupt: new presentation, blocked winner; write one clears

    assign ev[`IPRR_BIT_EV_NEW] = present_d && !req_q;
    assign ev[`IPRR_BIT_EV_BLOCKED] = rif.win_valid && !present_d;

    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_fire && awaddr_q == `IPRR_OFF_IRQ_STAT && wstrb_q[0]) begin
            irq_stat_d = irq_stat_q & ~wdata_q[1:0];
        end
        irq_stat_d = irq_stat_d | ev;          // set wins over clear
    end

    // sticky status and level output
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_stat_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign o_req = req_q;
    assign o_req_num = req_num_q;
    assign o_req_vector = req_vec_q;
    assign o_req_level = req_lvl_q;
    assign o_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    reserved_flags_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (flag_q & ~`IPRR_IMPL_MASK) == '0)
        else $error("reserved source flag set");

    event_sets_flag_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_src_event[5] && !en_q[5]) |=> flag_q[5])
        else $error("event lost while enable clear");

    vector_offset_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_req |-> (o_req_vector == {1'b0, o_req_num} + 7'h08 && o_req_vector <= 7'h3D))
        else $error("vector is not number plus eight");

    present_follows_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
        present_d |=> (o_req && o_req_num == $past(rif.win_num) && o_req_level > $past(cpu_lvl_q[2:0])))
        else $error("presented request does not match winner");

    above_cpu_level_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (rif.win_valid && {1'b0, rif.win_level} <= cpu_lvl_q) |=> !o_req)
        else $error("request presented at or below cpu level");

    nesting_blocks_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (nest_dis_q && i_in_service) |=> !o_req)
        else $error("request presented while nesting disabled");

    level_frozen_a: assert property (@(posedge i_clk) disable iff (i_reset)
        nest_dis_q |=> $stable(cpu_lvl_q))
        else $error("cpu level changed while nesting disabled");

    temp_mask_holds_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (temp_mask_q && rif.win_valid && rif.win_level < 3'h7) |=> !o_req)
        else $error("level six or lower presented under temporary mask");

    level_zero_hidden_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_req |-> o_req_level != 3'h0)
        else $error("level zero source presented");

    nibble_top_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
        ($rose(s_axi_rvalid) && $past(s_axi_araddr) >= `IPRR_OFF_PRIO_FIRST
            && $past(s_axi_araddr) <= `IPRR_OFF_PRIO_LAST && s_axi_rresp == 2'h0)
        |-> (s_axi_rdata & 32'h8888_8888) == '0)
        else $error("nibble top bit read as one");

endmodule // iprr_top

// ===== iprr_consts.svh
/*
 * constants of the interrupt priority resolver: source count, vector base,
 * register byte offsets, field positions and reset values.
 * assumes inclusion by bare name from the package; the design modules use its macros without including it.
 */
`ifndef IPRR_CONSTS_SVH
`define IPRR_CONSTS_SVH

// source numbering and vector mapping
`define IPRR_NSRC 54
`define IPRR_VEC_BASE 7'h08
`define IPRR_TOP_LEVEL 3'h7
// implemented sources: 0..25, 39, 40, 43; all others never request
`define IPRR_IMPL_MASK 54'h980_03FF_FFFF

// register byte offsets
`define IPRR_OFF_FLAG_LO 8'h00
`define IPRR_OFF_FLAG_HI 8'h04
`define IPRR_OFF_EN_LO 8'h08
`define IPRR_OFF_EN_HI 8'h0C
`define IPRR_OFF_PRIO_FIRST 8'h10
`define IPRR_OFF_PRIO_LAST 8'h28
`define IPRR_OFF_CTL_ONE 8'h2C
`define IPRR_OFF_CTL_TWO 8'h30
`define IPRR_OFF_CPU_LVL 8'h34
`define IPRR_OFF_WIN_STAT 8'h38
`define IPRR_OFF_IRQ_STAT 8'h3C
`define IPRR_OFF_IRQ_MASK 8'h40

// field positions
`define IPRR_BIT_NEST_DIS 15
`define IPRR_BIT_TEMP_MASK 14
`define IPRR_BIT_EV_NEW 0
`define IPRR_BIT_EV_BLOCKED 1
`define IPRR_NIB_PER_WORD 8

// reset values
`define IPRR_RST_LEVEL 3'h0
`define IPRR_RST_CPU_LVL 4'h0
`define IPRR_RST_WORD 32'h0000_0000

// bus responses
`define IPRR_RESP_OKAY 2'h0
`define IPRR_RESP_SLVERR 2'h2

`endif

// ===== iprr_pkg.sv
/*
 * types shared by the resolver modules and their interface.
 * assumes iprr_consts.svh is on the include path.
 */
`include "iprr_consts.svh"

package iprr_pkg;
    typedef logic [5:0] iprr_src_type;                   // interrupt number
    typedef logic [2:0] iprr_level_type;                 // user priority level
    typedef logic [`IPRR_NSRC-1:0] iprr_vec_type;        // one bit per source
    typedef logic [`IPRR_NSRC-1:0][2:0] iprr_levels_type; // level per source
endpackage

// ===== iprr_resolve_if.sv
/*
 * carrier between the register/control logic and the winner resolver.
 * assumes both ends run on the same clock; contents are combinational.
 */
`timescale 1ns/1ps

interface iprr_resolve_if;
    import iprr_pkg::*;
    iprr_vec_type pending;        // enabled, flagged sources
    iprr_levels_type levels;      // user level of every source
    logic win_valid;              // some source eligible
    iprr_src_type win_num;        // winning interrupt number
    iprr_level_type win_level;    // level of the winner

    modport ctrl (output pending, output levels, input win_valid, input win_num, input win_level);
    modport resolver (input pending, input levels, output win_valid, output win_num, output win_level);
endinterface // iprr_resolve_if

// ===== iprr_resolver.sv
/*
 * combinational winner search over all sources: highest user level first,
 * lowest interrupt number among equal levels.
 * assumes pending bits are already gated by enables.
 */
`timescale 1ns/1ps

module iprr_resolver
    import iprr_pkg::*;
(
    input wire logic i_clk,                    // clock, used by checks only
    input wire logic i_reset,                  // sync reset, used by checks only
    iprr_resolve_if.resolver rif               // pending sources in, winner out
);

    ////////////////////////////////////////////////////////////////////////
    // chain from number 53 down to 0; a lower number takes over on equal level

    logic [`IPRR_NSRC:0] stage_valid;          // winner found at or above stage
    iprr_src_type stage_num [`IPRR_NSRC:0];    // winner number per stage
    iprr_level_type stage_level [`IPRR_NSRC:0]; // winner level per stage

    assign stage_valid[`IPRR_NSRC] = 1'b0;
    assign stage_num[`IPRR_NSRC] = 6'h00;
    assign stage_level[`IPRR_NSRC] = 3'h0;

    genvar gi;
    generate
        for (gi = 0; gi < `IPRR_NSRC; gi++) begin : g_stage
            logic take;                        // this source replaces the one so far
            // level zero never competes; higher level beats lower
            assign take = rif.pending[gi] && (rif.levels[gi] != 3'h0) &&
                (!stage_valid[gi+1] || (rif.levels[gi] >= stage_level[gi+1]));
            assign stage_valid[gi] = stage_valid[gi+1] || take;
            assign stage_num[gi] = take ? 6'(gi) : stage_num[gi+1];
            assign stage_level[gi] = take ? rif.levels[gi] : stage_level[gi+1];
        end
    endgenerate

    assign rif.win_valid = stage_valid[0];
    assign rif.win_num = stage_num[0];
    assign rif.win_level = stage_level[0];

    ////////////////////////////////////////////////////////////////////////
    // checks

    winner_nonzero_a: assert property (@(posedge i_clk) disable iff (i_reset)
        rif.win_valid |-> (rif.win_level != 3'h0 && rif.pending[rif.win_num]))
        else $error("winner has level zero or is not pending");

    winner_beats_higher_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (rif.win_valid && rif.win_num != 6'h00 && rif.pending[0] && rif.levels[0] != 3'h0)
        |-> (rif.win_level > rif.levels[0]))
        else $error("source zero lost without a strictly higher level");

endmodule // iprr_resolver

// ===== iprr_core_model.sv
/* core model: takes a presented request into service when told to.
   assumes the bench drives i_take and i_done on the rising edge of i_clk. */
`timescale 1ns/1ps
module iprr_core_model (
    input wire logic i_clk,    // instruction clock
    input wire logic i_reset,  // sync reset, active high
    input wire logic i_req,    // request presented by the resolver
    input wire logic i_take,   // accept a presented request
    input wire logic i_done,   // service finished
    output logic o_in_service  // core is servicing
);
    // service starts only from a request that is actually presented
    always_ff @(posedge i_clk) begin
        if (i_reset || i_done) begin
            o_in_service <= 1'b0;
        end else if (i_take && i_req) begin
            o_in_service <= 1'b1;
        end
    end
endmodule // iprr_core_model

// ===== iprr_top_tb.sv
/* bench for the resolver: single sources from a table, then ties, gating, masks, irq and bus errors.
   assumes iprr_consts.svh on the include path and iprr_core_model compiled first. */
`timescale 1ns/1ps
module iprr_top_tb;
    import iprr_pkg::*;
    logic i_clk = 0, i_reset = 1, in_take = 0, in_done = 0, i_in_service;
    logic [`IPRR_NSRC-1:0] i_src_event = '0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_req, o_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs_q;
    iprr_src_type o_req_num;
    logic [6:0] o_req_vector;
    iprr_level_type o_req_level;
    logic [31:0] pw [7] = '{default: 32'h0}; // shadow of the priority words
    int err_count = 0, checks = 0;
    int rows [6][2] = '{'{0, 1}, '{3, 5}, '{25, 7}, '{39, 2}, '{40, 3}, '{43, 7}}; // source, level
    always #20 i_clk = ~i_clk;
    iprr_top iprr_top_inst (.i_clk, .i_reset, .i_src_event, .i_in_service, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .o_req, .o_req_num, .o_req_vector, .o_req_level, .o_irq);
    iprr_core_model iprr_core_model_inst (.i_clk, .i_reset, .i_req(o_req), .i_take(in_take),
        .i_done(in_done), .o_in_service(i_in_service));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // write: address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge i_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs_q = s_axi_bresp;
    endtask
    task rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge i_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_q = s_axi_rdata;
        rs_q = s_axi_rresp;
    endtask
    task pr(input int n, input logic [2:0] l);
        pw[n/8][4*(n%8)+:3] = l;
        wr(8'h10 + 8'(4 * (n / 8)), pw[n/8]);
    endtask
    // pulse events, check the presentation and the low flags, then clear the flags
    task ev(input logic [`IPRR_NSRC-1:0] m, input logic r, input int n, input logic [2:0] l);
        @(posedge i_clk);
        i_src_event <= m;
        @(posedge i_clk);
        i_src_event <= '0;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk("req", 32'(r), 32'(o_req));
        if (r) begin
            chk("num", n, 32'(o_req_num));
            chk("vector", n + 8, 32'(o_req_vector));
            chk("level", 32'(l), 32'(o_req_level));
        end
        rd(8'h00);
        chk("flags", 32'(m & `IPRR_IMPL_MASK), rd_q);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        @(negedge i_clk);
        chk("rst vector", 8, 32'(o_req_vector));
        chk("rst ready", 32'h3, 32'({s_axi_awready, s_axi_arready}));
        chk("rst req", 0, 32'({o_req, o_irq, o_req_level}));
        rd(8'h10);
        chk("rst prio", 0, rd_q);
        wr(8'h08, 32'hFFFF_FFFF);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C);
        chk("enable hi", 32'h0000_0980, rd_q);
        foreach (rows[i]) begin
            pr(rows[i][0], 3'(rows[i][1]));
            ev(54'h1 << rows[i][0], 1'b1, rows[i][0], 3'(rows[i][1]));
            pr(rows[i][0], 3'h0);
        end
        pr(3, 3'h4);
        pr(40, 3'h4);
        ev((54'h1 << 40) | (54'h1 << 3), 1'b1, 3, 3'h4);
        pr(0, 3'h1);
        pr(43, 3'h6);
        ev((54'h1 << 43) | (54'h1 << 3) | 54'h1, 1'b1, 43, 3'h6);
        ev(54'h1 << 5, 1'b0, 0, 3'h0);
        pr(30, 3'h7);
        ev(54'h1 << 30, 1'b0, 0, 3'h0);
        pr(5, 3'h3);
        wr(8'h08, 32'hFFFF_FFDF);
        ev(54'h1 << 5, 1'b0, 0, 3'h0);
        wr(8'h08, 32'hFFFF_FFFF);
        wr(8'h34, 32'h5);
        pr(9, 3'h5);
        ev(54'h1 << 9, 1'b0, 0, 3'h0);
        pr(9, 3'h6);
        ev(54'h1 << 9, 1'b1, 9, 3'h6);
        wr(8'h34, 32'h0);
        wr(8'h30, 32'h4000);
        ev(54'h1 << 9, 1'b0, 0, 3'h0);
        pr(12, 3'h7);
        ev(54'h1 << 12, 1'b1, 12, 3'h7);
        wr(8'h30, 32'h0);
        wr(8'h2C, 32'h8000);
        in_take <= 1'b1;
        ev(54'h1 << 9, 1'b1, 9, 3'h6);
        ev(54'h1 << 12, 1'b0, 0, 3'h0);
        wr(8'h34, 32'h3);
        rd(8'h34);
        chk("cpu level", 0, rd_q);
        in_done <= 1'b1;
        wr(8'h2C, 32'h0);
        in_done <= 1'b0;
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14);
        chk("prio nibbles", 32'h7777_7777, rd_q);
        wr(8'h3C, 32'h3);
        wr(8'h40, 32'h1);
        ev(54'h1 << 12, 1'b1, 12, 3'h7);
        @(negedge i_clk);
        chk("irq set", 1, 32'(o_irq));
        wr(8'h40, 32'h0);
        @(negedge i_clk);
        chk("irq masked", 0, 32'(o_irq));
        wr(8'h40, 32'h1);
        wr(8'h3C, 32'h1);
        @(negedge i_clk);
        chk("irq cleared", 0, 32'(o_irq));
        wr(8'h09, 32'h0);
        chk("unaligned bresp", 2, 32'(rs_q));
        rd(8'h08);
        chk("unaligned wr", 32'h03FF_FFFF, rd_q);
        wr(8'h44, 32'h1);
        chk("bresp", 2, 32'(rs_q));
        rd(8'h44);
        chk("rresp", 2, 32'(rs_q));
        print_verdict();
    end
endmodule // iprr_top_tb
